// ==== verilog/pmpl_check.sv ====
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
// Operation
// (RULE1) Unlocked shared: no exec, M rw, S/U by X
// (RULE2) Locked shared: no write, exec both, M read if X
// (RULE3) Locked shared entry ignores writes unless bypass
// (RULE4) All-ones nibble: locked shared read-only data
// (RULE5) Drop executable M-only or shared config writes
// (RULE6) M fetch only from M-only or shared code
// (RULE7) Without lockdown, read-clear write-set stays reserved
// (RULE8) All-clear nibble faults every mode
// (RULE9) Unlocked plain entry: M faults, S/U encoded
// (RULE10) Locked plain entry: M encoded, S/U faults
// (RULE11) Locked shared with X: S/U exec, M rx
// (RULE12) Lockdown, allowlist sticky; bypass sticky when clear; code keeps bypass clear only while an entry is locked
// (RULE13) Locked entry with bypass clear freezes bypass
// (RULE14) Boot firmware sets flags early for discovery
// (RULE15) Software places locked entries at higher priority
// (RULE16) Bypass may be tied to zero
// (RULE17) Security config 64 bits, split halves
// (RULE18) Bit 2 bypass lets locked entries change
// (RULE19) Bit 1 allowlist denies unmatched M accesses
// (RULE20) Bit 0 lockdown changes lock meaning
// (RULE21) Lowest matching entry index decides
// (RULE22) Denied access raises matching fault, suppressed
module pmpl_check
  import pmpl_pkg::*;
#(
  parameter bit RLB_EN = 1'b1
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [AXW-1:0]   s_axi_awaddr,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  output logic [1:0]            s_axi_bresp,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  input  wire logic [AXW-1:0]   s_axi_araddr,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  input  wire logic             chk_valid,
  input  wire logic [31:0]      chk_addr,
  input  wire pmpl_acc_t        chk_type,
  input  wire logic             chk_priv_m,
  output logic                  rsp_valid_q,
  output logic                  rsp_allow_q,
  output logic                  rsp_fetch_fault_q,
  output logic                  rsp_load_fault_q,
  output logic                  rsp_store_fault_q
);

  // ****************************************
  // State
  // ****************************************
  logic             mml_q, machine_allowlist_policy_flag_q, rlb_q;
  logic [7:0]       cfg_q  [NENT];
  logic [31:0]      addr_q [NENT];
  logic [31:0]      faults_q;
  logic             aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [AXW-1:0]   aw_addr_q;
  logic [31:0]      w_data_q, rdata_q;
  logic [3:0]       w_strb_q;
  logic [1:0]       bresp_q, rresp_q;
  logic             wr_fire;
  logic [NENT-1:0]  match, lockbit;
  logic             any_l, hit;
  logic [3:0]       nib;
  logic [2:0]       perm;
  logic             ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [AXW-1:0] ent_off(input logic [AXW-1:0] base, input int i);
    return base + ENT_STRIDE * AXW'(i);
  endfunction : ent_off

  // ****************************************
  // Bus slave: write path
  // ****************************************
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  // Locked writes still answer OKAY: the value simply stays, as software expects of WARL fields
  always_ff @(posedge clock) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (aw_addr_q == OFF_SECCFG || aw_addr_q == OFF_SECCFGH || aw_addr_q == OFF_FAULTS
                   || (aw_addr_q >= OFF_CFG0 && aw_addr_q < ent_off(OFF_CFG0, NENT) && aw_addr_q[1:0] == 2'b00)
                   || (aw_addr_q >= OFF_ADDR0 && aw_addr_q < ent_off(OFF_ADDR0, NENT) && aw_addr_q[1:0] == 2'b00))
                  ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Security configuration flags
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      {rlb_q, machine_allowlist_policy_flag_q, mml_q} <= SECCFG_RST;
    end else if (wr_fire && aw_addr_q == OFF_SECCFG && w_strb_q[0]) begin
      mml_q  <= mml_q | w_data_q[SEC_MML];                                  // RULE12 RULE20
      machine_allowlist_policy_flag_q <= machine_allowlist_policy_flag_q | w_data_q[SEC_MACHINE_ALLOWLIST_POLICY_FLAG];                                // RULE12 RULE19
      if (RLB_EN && (rlb_q || !any_l)) begin                                // RULE13 RULE16
        rlb_q <= w_data_q[SEC_RLB];                                         // RULE18
      end
    end
  end

  // ****************************************
  // Entries
  // ****************************************
  for (genvar i = 0; i < NENT; i++) begin : g_ent
    logic [31:0] lo;
    logic [7:0]  nc;
    logic        drop;
    assign lo         = (i == 0) ? 32'h0 : addr_q[(i == 0) ? 0 : i-1];
    // Nonzero address mode means top-of-range against the previous entry
    assign match[i]   = (cfg_q[i][CFG_A +: 2] != 2'b00) && chk_addr >= lo && chk_addr < addr_q[i];
    assign lockbit[i] = cfg_q[i][CFG_L];
    assign nc         = w_data_q[7:0];
    // Executable M-only or locked shared code may not be added once lockdown is on and bypass is clear
    assign drop = mml_q && !rlb_q && nc[CFG_L] && !(nc[CFG_R] && nc[CFG_W] && nc[CFG_X])
                  && (nc[CFG_X] || (!nc[CFG_R] && nc[CFG_W]));               // RULE5

    always_ff @(posedge clock) begin
      if (reset) begin
        cfg_q[i] <= CFG_RST;
      end else if (wr_fire && aw_addr_q == ent_off(OFF_CFG0, i) && w_strb_q[0]
                   && (!lockbit[i] || rlb_q) && !drop) begin                 // RULE3 RULE18
        cfg_q[i] <= nc;
      end
    end

    always_ff @(posedge clock) begin
      if (reset) begin
        addr_q[i] <= ADDR_RST;
      end else if (wr_fire && aw_addr_q == ent_off(OFF_ADDR0, i) && (!lockbit[i] || rlb_q)) begin // RULE3
        addr_q[i] <= merge(addr_q[i], w_data_q, w_strb_q);
      end
    end
  end

  assign any_l = |lockbit;

  // ****************************************
  // Bus slave: read path
  // ****************************************
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
      if (s_axi_araddr == OFF_SECCFG) begin
        rdata_q <= {29'h0, rlb_q, machine_allowlist_policy_flag_q, mml_q};                           // RULE17
      end else if (s_axi_araddr == OFF_SECCFGH) begin
        rdata_q <= 32'h0;
      end else if (s_axi_araddr == OFF_FAULTS) begin
        rdata_q <= faults_q;
      end else begin
        rresp_q <= RESP_SLVERR;
        for (int i = 0; i < NENT; i++) begin
          if (s_axi_araddr == ent_off(OFF_CFG0, i)) begin
            rdata_q <= {24'h0, cfg_q[i]};
            rresp_q <= RESP_OKAY;
          end
          if (s_axi_araddr == ent_off(OFF_ADDR0, i)) begin
            rdata_q <= addr_q[i];
            rresp_q <= RESP_OKAY;
          end
        end
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Permission check
  // ****************************************
  always_comb begin
    hit = 1'b0;
    nib = 4'h0;
    for (int i = NENT-1; i >= 0; i--) begin
      if (match[i]) begin                                                   // RULE21
        hit = 1'b1;
        nib = {cfg_q[i][CFG_L], cfg_q[i][CFG_R], cfg_q[i][CFG_W], cfg_q[i][CFG_X]};
      end
    end
  end

  // perm is {read, write, execute}
  always_comb begin
    perm = 3'b000;
    if (!hit) begin
      // Unmatched M access: allowed unless allowlist; never fetch under lockdown
      perm = chk_priv_m ? {!machine_allowlist_policy_flag_q, !machine_allowlist_policy_flag_q, !machine_allowlist_policy_flag_q && !mml_q} : 3'b000; // RULE6 RULE19
    end else if (mml_q) begin
      case (nib)
        4'b0010: perm = chk_priv_m ? 3'b110 : 3'b100;                       // RULE1
        4'b0011: perm = 3'b110;                                             // RULE1
        4'b1010: perm = 3'b001;                                             // RULE2
        4'b1011: perm = chk_priv_m ? 3'b101 : 3'b001;                       // RULE2 RULE11
        4'b1111: perm = 3'b100;                                             // RULE4
        default: perm = (nib[3] == chk_priv_m) ? nib[2:0] : 3'b000;         // RULE8 RULE9 RULE10
      endcase
    end else if (nib[2:1] == 2'b01) begin
      perm = 3'b000;                                                        // RULE7
    end else begin
      perm = (!chk_priv_m || nib[3]) ? nib[2:0] : 3'b111;
    end
  end

  assign ok = (chk_type == ACC_FETCH) ? perm[0] : (chk_type == ACC_LOAD) ? perm[2] : perm[1];

  always_ff @(posedge clock) begin
    if (reset) begin
      rsp_valid_q       <= 1'b0;
      rsp_allow_q       <= 1'b0;
      rsp_fetch_fault_q <= 1'b0;
      rsp_load_fault_q  <= 1'b0;
      rsp_store_fault_q <= 1'b0;
    end else begin
      rsp_valid_q       <= chk_valid;
      rsp_allow_q       <= chk_valid && ok;                                 // RULE22
      rsp_fetch_fault_q <= chk_valid && !ok && chk_type == ACC_FETCH;       // RULE22
      rsp_load_fault_q  <= chk_valid && !ok && chk_type == ACC_LOAD;        // RULE22
      rsp_store_fault_q <= chk_valid && !ok && chk_type == ACC_STORE;       // RULE22
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      faults_q <= '0;
    end else if (chk_valid && !ok) begin
      faults_q <= faults_q + 32'h1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_shared_data_nox;
    @(posedge clock) disable iff (reset)
      chk_valid && mml_q && hit && nib[3:1] == 3'b001 && chk_type == ACC_FETCH |=> rsp_fetch_fault_q;
  endproperty
  a_shared_data_nox: assert property (p_shared_data_nox) else $error("shared data fetched"); // RULE1

  property p_shared_code_now;
    @(posedge clock) disable iff (reset)
      chk_valid && mml_q && hit && nib[3:1] == 3'b101 && chk_type == ACC_STORE |=> rsp_store_fault_q;
  endproperty
  a_shared_code_now: assert property (p_shared_code_now) else $error("shared code written"); // RULE2

  property p_locked_hold;
    @(posedge clock) disable iff (reset)
      cfg_q[0][CFG_L] && !rlb_q |=> $stable(cfg_q[0]) && $stable(addr_q[0]);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("locked entry changed"); // RULE3

  property p_all_ones_ro;
    @(posedge clock) disable iff (reset)
      chk_valid && mml_q && hit && nib == 4'hf |=> rsp_valid_q && (rsp_allow_q == $past(chk_type == ACC_LOAD));
  endproperty
  a_all_ones_ro: assert property (p_all_ones_ro) else $error("all-ones entry misread"); // RULE4

  property p_mfetch_nohit;
    @(posedge clock) disable iff (reset)
      chk_valid && mml_q && !hit && chk_priv_m && chk_type == ACC_FETCH |=> rsp_fetch_fault_q && !rsp_allow_q;
  endproperty
  a_mfetch_nohit: assert property (p_mfetch_nohit) else $error("unmatched M fetch allowed"); // RULE6

  property p_reserved;
    @(posedge clock) disable iff (reset)
      chk_valid && !mml_q && hit && nib[2:1] == 2'b01 |=> !rsp_allow_q;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved encoding granted"); // RULE7

  property p_zero_nib;
    @(posedge clock) disable iff (reset)
      chk_valid && mml_q && hit && nib[2:0] == 3'b000 |=> rsp_valid_q && !rsp_allow_q;
  endproperty
  a_zero_nib: assert property (p_zero_nib) else $error("empty entry granted"); // RULE8

  property p_sticky;
    @(posedge clock) disable iff (reset)
      mml_q && machine_allowlist_policy_flag_q |=> mml_q && machine_allowlist_policy_flag_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky flag cleared"); // RULE12

  property p_rlb_frozen;
    @(posedge clock) disable iff (reset)
      !rlb_q && any_l |=> !rlb_q;
  endproperty
  a_rlb_frozen: assert property (p_rlb_frozen) else $error("bypass set after lock"); // RULE13

  property p_fault_excl;
    @(posedge clock) disable iff (reset)
      rsp_valid_q |-> rsp_allow_q != (rsp_fetch_fault_q || rsp_load_fault_q || rsp_store_fault_q);
  endproperty
  a_fault_excl: assert property (p_fault_excl) else $error("grant and fault together"); // RULE22

  c_mml_fault: cover property (@(posedge clock) disable iff (reset) mml_q && rsp_fetch_fault_q);
  c_shared: cover property (@(posedge clock) disable iff (reset) chk_valid && mml_q && hit && nib == 4'hb);
  c_rlb_lock: cover property (@(posedge clock) disable iff (reset) !rlb_q && any_l && mml_q);

endmodule : pmpl_check

// ==== verilog/pmpl_pkg.sv ====
package pmpl_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NENT = 8;
  localparam int AXW  = 12;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [AXW-1:0] OFF_SECCFG  = 12'h000;
  localparam logic [AXW-1:0] OFF_SECCFGH = 12'h004;
  localparam logic [AXW-1:0] OFF_FAULTS  = 12'h008;
  localparam logic [AXW-1:0] OFF_CFG0    = 12'h020;
  localparam logic [AXW-1:0] OFF_ADDR0   = 12'h040;
  localparam logic [AXW-1:0] ENT_STRIDE  = 12'h004;

  // Architectural numbers of the security configuration halves
  localparam logic [11:0] CSR_SECCFG  = 12'h747;
  localparam logic [11:0] CSR_SECCFGH = 12'h757;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SEC_MML  = 0;
  localparam int SEC_MACHINE_ALLOWLIST_POLICY_FLAG = 1;
  localparam int SEC_RLB  = 2;
  localparam int CFG_R    = 0;
  localparam int CFG_W    = 1;
  localparam int CFG_X    = 2;
  localparam int CFG_A    = 3;
  localparam int CFG_L    = 7;

  // ****************************************
  // Reset values and bus answers
  // ****************************************
  localparam logic [2:0]  SECCFG_RST = 3'h0;
  localparam logic [7:0]  CFG_RST    = 8'h00;
  localparam logic [31:0] ADDR_RST   = 32'h0;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ACC_FETCH, ACC_LOAD, ACC_STORE} pmpl_acc_t;

endpackage : pmpl_pkg

// ==== tb/pmpl_hart_model.sv ====
`timescale 1ns/10ps
// ****************************************
// Hart fetch and load/store stand-in
// ****************************************
module pmpl_hart_model
  import pmpl_pkg::*;
(
  input  wire logic   clock,
  output logic        chk_valid,
  output logic [31:0] chk_addr,
  output pmpl_acc_t   chk_type,
  output logic        chk_priv_m
);
  initial begin
    chk_valid  = 1'b0;
    chk_addr   = 32'h0;
    chk_type   = ACC_LOAD;
    chk_priv_m = 1'b1;
  end

  // Address is inverted once withdrawn so a stale value never passes for a live one
  task automatic issue(input logic [31:0] a, input pmpl_acc_t t, input logic m);
    @(posedge clock);
    chk_valid  <= 1'b1;
    chk_addr   <= a;
    chk_type   <= t;
    chk_priv_m <= m;
    @(posedge clock);
    chk_valid <= 1'b0;
    chk_addr  <= ~a;
  endtask : issue
endmodule : pmpl_hart_model

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`define CMP(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top
  import pmpl_pkg::*;
;
  logic             clock;
  logic             reset;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [AXW-1:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata;
  logic [3:0]       s_axi_wstrb;
  logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic             s_axi_rvalid, s_axi_rready;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic             chk_valid, chk_priv_m;
  logic [31:0]      chk_addr;
  pmpl_acc_t        chk_type;
  logic             rsp_valid_q, rsp_allow_q, rsp_fetch_fault_q, rsp_load_fault_q, rsp_store_fault_q;
  int               err_count, n_compared, n_denied;
  logic [3:0]       exp_q[$];
  logic [1:0]       bq[$];
  logic [33:0]      rq[$];
  logic [3:0]       ev;
  logic [1:0]       bv;
  logic [33:0]      rv;
  // Lockdown permissions per nibble, {M r,w,x, S/U r,w,x}
  localparam logic [5:0] PERM [16] = '{6'h00, 6'h01, 6'h34, 6'h36, 6'h04, 6'h05, 6'h06, 6'h07,
                                       6'h00, 6'h08, 6'h09, 6'h29, 6'h20, 6'h28, 6'h30, 6'h24};

  pmpl_check #(.RLB_EN(1'b1)) uut (
    .clock(clock), .reset(reset),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .chk_valid(chk_valid),
    .chk_addr(chk_addr), .chk_type(chk_type), .chk_priv_m(chk_priv_m),
    .rsp_valid_q(rsp_valid_q), .rsp_allow_q(rsp_allow_q), .rsp_fetch_fault_q(rsp_fetch_fault_q),
    .rsp_load_fault_q(rsp_load_fault_q), .rsp_store_fault_q(rsp_store_fault_q));

  pmpl_hart_model hart (.clock(clock), .chk_valid(chk_valid), .chk_addr(chk_addr),
                        .chk_type(chk_type), .chk_priv_m(chk_priv_m));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic conclude();
    if (exp_q.size() != 0)
      err_count++;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic wr(input logic [AXW-1:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, tk;
    bq.push_back(r);
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(negedge clock);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tk = s_axi_bvalid;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tk) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [AXW-1:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tk;
    rq.push_back({r, d});
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(negedge clock);
      ta = s_axi_arvalid & s_axi_arready;
      tk = s_axi_rvalid;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tk) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  function automatic logic pick(input logic [2:0] p, input pmpl_acc_t t);
    return (t == ACC_FETCH) ? p[0] : (t == ACC_LOAD) ? p[2] : p[1];
  endfunction : pick

  function automatic logic [31:0] rnd_lo();
    return $urandom & 32'h0000_00fc;
  endfunction : rnd_lo

  task automatic chk(input logic [31:0] a, input pmpl_acc_t t, input logic m, input logic ok);
    exp_q.push_back(ok ? 4'h8 : (t == ACC_FETCH) ? 4'h4 : (t == ACC_LOAD) ? 4'h2 : 4'h1);
    if (!ok) n_denied++;
    hart.issue(a, t, m);
  endtask : chk

  // ****************************************
  // Result watcher
  // ****************************************
  always @(negedge clock) begin
    if (rsp_valid_q === 1'b1) begin
      ev = (exp_q.size() != 0) ? exp_q.pop_front() : 4'hf;
      `CMP("check result", ev, {rsp_allow_q, rsp_fetch_fault_q, rsp_load_fault_q, rsp_store_fault_q})
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      bv = bq.pop_front();
      `CMP("write response", bv, s_axi_bresp)
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      rv = rq.pop_front();
      `CMP("read answer", rv, {s_axi_rresp, s_axi_rdata})
    end
  end

  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    $display("[FAIL] watchdog expected end seen hang");
    conclude();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0]  cfg;
    logic [31:0] a32;
    {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
    {err_count, n_compared, n_denied} = 96'h0;
    void'($urandom(77));
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rd(OFF_SECCFG, 32'h0, RESP_OKAY);
    wr(OFF_ADDR0, 32'h100, RESP_OKAY);
    a32 = $urandom;
    wr(OFF_ADDR0 + 12'h01c, a32, RESP_OKAY);
    rd(OFF_ADDR0 + 12'h01c, a32, RESP_OKAY);
    wr(12'h0fc, 32'h1, RESP_SLVERR);
    rd(12'h0fc, 32'h0, RESP_SLVERR);
    rd(OFF_SECCFGH, 32'h0, RESP_OKAY);
    wr(OFF_CFG0, 32'h0a, RESP_OKAY);
    chk(rnd_lo(), ACC_LOAD, 1'b0, 1'b0);
    chk(rnd_lo(), ACC_STORE, 1'b0, 1'b0);
    chk(32'h300 | rnd_lo(), ACC_FETCH, 1'b1, 1'b1);
    // Boot-time order: bypass first so executable shared rules can still be placed
    wr(OFF_SECCFG, 32'h4, RESP_OKAY);
    wr(OFF_SECCFG, 32'h5, RESP_OKAY);
    wr(OFF_SECCFG, 32'h4, RESP_OKAY);
    rd(OFF_SECCFG, 32'h5, RESP_OKAY);
    for (int n = 0; n < 16; n++) begin
      cfg = {n[3], 2'b00, 2'b01, n[0], n[1], n[2]};
      wr(OFF_CFG0, {24'h0, cfg}, RESP_OKAY);
      rd(OFF_CFG0, {24'h0, cfg}, RESP_OKAY);
      for (int t = 0; t < 3; t++) begin
        chk(rnd_lo(), pmpl_acc_t'(t), 1'b1, pick(PERM[n][5:3], pmpl_acc_t'(t)));
        chk(rnd_lo(), pmpl_acc_t'(t), 1'b0, pick(PERM[n][2:0], pmpl_acc_t'(t)));
      end
    end
    chk(32'h300 | rnd_lo(), ACC_LOAD, 1'b1, 1'b1);
    chk(32'h300 | rnd_lo(), ACC_FETCH, 1'b1, 1'b0);
    chk(32'h300 | rnd_lo(), ACC_LOAD, 1'b0, 1'b0);
    wr(OFF_SECCFG, 32'h7, RESP_OKAY);
    chk(32'h300 | rnd_lo(), ACC_STORE, 1'b1, 1'b0);
    wr(OFF_CFG0, 32'h8a, RESP_OKAY);
    wr(OFF_SECCFG, 32'h3, RESP_OKAY);
    wr(OFF_SECCFG, 32'h7, RESP_OKAY);
    rd(OFF_SECCFG, 32'h3, RESP_OKAY);
    wr(OFF_CFG0, 32'h0b, RESP_OKAY);
    rd(OFF_CFG0, 32'h8a, RESP_OKAY);
    wr(OFF_ADDR0, 32'h200, RESP_OKAY);
    rd(OFF_ADDR0, 32'h100, RESP_OKAY);
    chk(rnd_lo(), ACC_FETCH, 1'b0, 1'b1);
    wr(OFF_CFG0 + 12'h004, 32'h8c, RESP_OKAY);
    rd(OFF_CFG0 + 12'h004, 32'h0, RESP_OKAY);
    wr(OFF_CFG0 + 12'h004, 32'h8e, RESP_OKAY);
    rd(OFF_CFG0 + 12'h004, 32'h0, RESP_OKAY);
    wr(OFF_CFG0 + 12'h004, 32'h89, RESP_OKAY);
    wr(OFF_CFG0 + 12'h004, 32'h00, RESP_OKAY);
    rd(OFF_CFG0 + 12'h004, 32'h89, RESP_OKAY);
    rd(OFF_FAULTS, 32'(n_denied), RESP_OKAY);
    // A protection reset in mid-run must clear even the sticky state
    @(posedge clock);
    reset <= 1'b1;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rd(OFF_SECCFG, 32'h0, RESP_OKAY);
    rd(OFF_CFG0, 32'h0, RESP_OKAY);
    repeat (4) @(posedge clock);
    conclude();
  end
endmodule : tb_top
